// >>> src/comm_loss_alarm_regs.vh
// Purpose: Constants for the communication-loss alarm monitor
// Assumes: 250 MHz system clock
// Notes: Action codes, detection time limits in seconds, and clock rate in Hz
`ifndef COMM_LOSS_ALARM_REGS_VH
`define COMM_LOSS_ALARM_REGS_VH
`define ACT_DISABLED 2'h0
`define ACT_WARN 2'h1
`define ACT_FAULT 2'h2
`define DET_MIN_SEC 10'h01E
`define DET_MAX_SEC 10'h258
`define DET_DEFAULT_SEC 10'h01E
`define CLK_HZ 28'hEE6B280
`define TICKS_PER_SEC (`CLK_HZ)
`endif

// >>> src/sec_tick.v
// Purpose: One-cycle pulse once per second from the system clock
// Assumes: Synchronous active-low reset; i_clear restarts the count
// Notes: Period is a parameter so simulation can shorten it
`timescale 1ns/1ps
`include "comm_loss_alarm_regs.vh"
module sec_tick #(
    parameter [27:0] TICKS = `TICKS_PER_SEC
) (
    input wire i_clk,
    input wire i_rst_b,
    input wire i_clear,
    output reg o_tick
);
    reg [27:0] cnt_q;
    always @(posedge i_clk)
    begin
        if (!i_rst_b || i_clear)
        begin
            cnt_q <= 28'h0000000;
            o_tick <= 1'b0;
        end
        else if (cnt_q == TICKS - 28'h0000001)
        begin
            cnt_q <= 28'h0000000;
            o_tick <= 1'b1;
        end
        else
        begin
            cnt_q <= cnt_q + 28'h0000001;
            o_tick <= 1'b0;
        end
    end
endmodule

// >>> src/comm_loss_alarm_monitor.v
// Purpose: Raise an alarm when the host serial link falls silent
// Assumes: i_msg_done is a one-cycle pulse per complete host message, same clock
// Notes: Detection time is clamped to its legal range
// Summary of operation
// - Supervise only in serial host mode
// - Alarm after silence equal to detection time
// - Detection time 30 to 600 s, default 30
// - Alarm clears itself on next message
// - Action disabled, warn-and-continue, or fault-stop
// - Fault stop needs separate restart request
`timescale 1ns/1ps
`include "comm_loss_alarm_regs.vh"
module comm_loss_alarm_monitor #(
    parameter [27:0] TICKS_PER_SEC = `TICKS_PER_SEC
) (
    input wire i_clk,
    input wire i_rst_b,
    input wire i_serial_mode,
    input wire [1:0] i_action,
    input wire [9:0] i_detect_sec,
    input wire i_msg_done,
    input wire i_restart_req,
    output reg o_comm_loss_alarm,
    output reg o_warn_continue_action,
    output reg o_fault_stop_action,
    output reg o_run_enable
);
    // Stop latch states
    localparam RUN_ST = 1'b0;
    localparam STOP_ST = 1'b1;

    wire active;
    wire timer_clear;
    wire tick;
    wire at_limit;
    reg [9:0] limit_q;
    reg [9:0] limit_d;
    reg [9:0] sec_q;
    reg [9:0] sec_d;
    reg expired_d;
    reg warn_d;
    reg fault_d;
    reg stop_q;
    reg stop_d;

    // Clamp a requested detection time into the legal window
    function [9:0] clamp_sec;
        input [9:0] req;
        begin
            if (req < `DET_MIN_SEC)
            begin
                clamp_sec = `DET_MIN_SEC;
            end
            else if (req > `DET_MAX_SEC)
            begin
                clamp_sec = `DET_MAX_SEC;
            end
            else
            begin
                clamp_sec = req;
            end
        end
    endfunction

    // Alarm is due and the setting selects this action
    function action_hit;
        input due;
        input [1:0] setting;
        input [1:0] code;
        begin
            action_hit = due && (setting == code);
        end
    endfunction

    assign active = i_serial_mode && (i_action != `ACT_DISABLED);
    assign timer_clear = !active || i_msg_done;
    assign at_limit = (sec_q >= limit_q);

    sec_tick #(
        .TICKS(TICKS_PER_SEC)
    ) u_tick (
        .i_clk(i_clk),
        .i_rst_b(i_rst_b),
        .i_clear(timer_clear),
        .o_tick(tick)
    );

    always @*
    begin
        limit_d = clamp_sec(i_detect_sec);
    end

    // Registered limit cuts the clamp out of the count path
    always @(posedge i_clk)
    begin
        if (!i_rst_b)
        begin
            limit_q <= `DET_DEFAULT_SEC;
        end
        else
        begin
            limit_q <= limit_d;
        end
    end

    // Whole seconds of silence, saturating at the limit
    always @*
    begin
        sec_d = sec_q;
        if (timer_clear)
        begin
            sec_d = 10'h000;
        end
        else if (sec_q > limit_q)
        begin
            // Limit lowered mid-count: pull back, never wrap
            sec_d = limit_q;
        end
        else if (tick && !at_limit)
        begin
            sec_d = sec_q + 10'h001;
        end
    end

    always @(posedge i_clk)
    begin
        if (!i_rst_b)
        begin
            sec_q <= 10'h000;
        end
        else
        begin
            sec_q <= sec_d;
        end
    end

    // Alarm and action decode for the coming cycle
    always @*
    begin
        expired_d = 1'b0;
        if (active && (sec_d >= limit_q))
        begin
            expired_d = 1'b1;
        end
        warn_d = action_hit(expired_d, i_action, `ACT_WARN);
        fault_d = action_hit(expired_d, i_action, `ACT_FAULT);
    end

    // Fault stop latch; only a restart request or reset releases it
    always @*
    begin
        stop_d = stop_q;
        case (stop_q)
            RUN_ST:
            begin
                if (fault_d)
                begin
                    stop_d = STOP_ST;
                end
            end
            STOP_ST:
            begin
                // A pending fault wins over restart
                if (!fault_d && i_restart_req)
                begin
                    stop_d = RUN_ST;
                end
            end
            default:
            begin
                stop_d = RUN_ST;
            end
        endcase
    end

    always @(posedge i_clk)
    begin
        if (!i_rst_b)
        begin
            stop_q <= RUN_ST;
        end
        else
        begin
            stop_q <= stop_d;
        end
    end

    // Alarm clears the cycle after a message
    always @(posedge i_clk)
    begin
        if (!i_rst_b)
        begin
            o_comm_loss_alarm <= 1'b0;
        end
        else
        begin
            o_comm_loss_alarm <= expired_d;
        end
    end

    always @(posedge i_clk)
    begin
        if (!i_rst_b)
        begin
            o_warn_continue_action <= 1'b0;
            o_fault_stop_action <= 1'b0;
        end
        else
        begin
            o_warn_continue_action <= warn_d;
            o_fault_stop_action <= fault_d;
        end
    end

    always @(posedge i_clk)
    begin
        if (!i_rst_b)
        begin
            o_run_enable <= 1'b1;
        end
        else
        begin
            o_run_enable <= (stop_d == RUN_ST);
        end
    end
endmodule

// >>> verif/comm_loss_alarm_monitor_chk.sv
// Purpose: Port checks for the alarm monitor
// Assumes: Sync active-low reset
// Notes: Bind at foot
`timescale 1ns/1ps
module clam_chk(
    input wire i_clk,
    input wire i_rst_b,
    input wire i_serial_mode,
    input wire [1:0] i_action,
    input wire i_msg_done,
    input wire i_restart_req,
    input wire o_comm_loss_alarm,
    input wire o_warn_continue_action,
    input wire o_fault_stop_action,
    input wire o_run_enable
);
default clocking @(posedge i_clk); endclocking
default disable iff (!i_rst_b);
a_serial_only: assert property (!i_serial_mode |=> !o_comm_loss_alarm) else $error("mode");
a_silence_cause: assert property ($rose(o_comm_loss_alarm) |-> !$past(i_msg_done)) else $error("msg");
a_msg_clears: assert property (i_msg_done |=> !o_comm_loss_alarm) else $error("clear");
a_off_quiet: assert property (i_action == 0 |=> !o_comm_loss_alarm) else $error("off");
a_warn_flag: assert property (o_warn_continue_action ==
    (o_comm_loss_alarm && $past(i_action) == 2'h1)) else $error("warn");
a_fault_stop: assert property (o_fault_stop_action |-> !o_run_enable) else $error("fault");
a_restart_only: assert property ($rose(o_run_enable) |->
    $past(i_restart_req) && !o_fault_stop_action) else $error("run");
endmodule
bind comm_loss_alarm_monitor clam_chk i_chk(
    .i_clk(i_clk),
    .i_rst_b(i_rst_b),
    .i_serial_mode(i_serial_mode),
    .i_action(i_action),
    .i_msg_done(i_msg_done),
    .i_restart_req(i_restart_req),
    .o_comm_loss_alarm(o_comm_loss_alarm),
    .o_warn_continue_action(o_warn_continue_action),
    .o_fault_stop_action(o_fault_stop_action),
    .o_run_enable(o_run_enable)
);

// >>> verif/host_model.sv
// Purpose: Host sending periodic messages
// Assumes: Gap shorter than detection time
// Notes: Stops while disabled
`timescale 1ns/1ps
module host_model(
    input wire i_clk,
    input wire i_en,
    output reg o_msg_done
);
int n = 0;
initial o_msg_done = 0;
always @(negedge i_clk)
begin
    n = (i_en && n < 20) ? n + 1 : 0;
    o_msg_done <= i_en && n == 20;
end
endmodule

// >>> verif/comm_loss_alarm_monitor_tb.sv
// Purpose: Alarm monitor bench
// Assumes: Two ticks per second
// Notes: Output changes checked in order
`timescale 1ns/1ps
module comm_loss_alarm_monitor_tb;
reg i_clk = 0, i_rst_b = 0, sm = 1, en = 1, rq = 0;
reg [1:0] act = 1;
reg [9:0] det = 0;
reg [31:0] s = 32'hD28F3420;
wire m;
wire [3:0] o;
logic [3:0] q[$];
logic [3:0] last = 4'h1;
int fail_count = 0, total_checks = 0, cyc = 0;
always #2 i_clk = ~i_clk;
host_model h(.i_clk, .i_en(en), .o_msg_done(m));
comm_loss_alarm_monitor #(.TICKS_PER_SEC(2)) i_dut(.i_clk, .i_rst_b, .i_serial_mode(sm), .i_action(act),
    .i_detect_sec(det), .i_msg_done(m), .i_restart_req(rq), .o_comm_loss_alarm(o[3]),
    .o_warn_continue_action(o[2]), .o_fault_stop_action(o[1]), .o_run_enable(o[0]));
function automatic [31:0] lfsr(input [31:0] v);
    lfsr = {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
endfunction
task conclude;
    $display("checks %0d fails %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0)
        $display("Testbench passed");
    else
        $display("Testbench failed");
    $finish;
endtask
task cmp(input logic [3:0] e);
    total_checks++;
    if (o !== e)
    begin
        fail_count++;
        $display("wrong value at %0t: outputs %b", $time, o);
    end
endtask
task stop(input logic [3:0] e, input bit p);
    @(posedge m);
    @(negedge i_clk) en = 0;
    repeat (55) @(negedge i_clk);
    if (p) q.push_back(e);
    repeat (25) @(negedge i_clk);
endtask
always @(negedge i_clk)
begin
    if (++cyc > 5000)
    begin
        fail_count++;
        conclude;
    end
    if (i_rst_b && o !== last)
    begin
        last = o;
        if (q.size() == 0)
        begin
            fail_count++;
            $display("wrong value at %0t: unexpected outputs %b", $time, o);
        end
        else
            cmp(q.pop_front());
    end
end
initial
begin
    repeat (8) @(negedge i_clk);
    i_rst_b = 1;
    s = lfsr(s);
    det = s[9:0] & 10'h1F;
    stop(4'hD, 1);
    en = 1; q.push_back(4'h1);
    @(posedge m);
    act = 2; stop(4'hA, 1);
    rq = 1; repeat (4) @(negedge i_clk); rq = 0;
    en = 1; q.push_back(4'h0); repeat (30) @(negedge i_clk);
    q.push_back(4'h1); rq = 1; @(negedge i_clk) rq = 0;
    for (int k = 0; k < 3; k++)
    begin
        act = (k == 2) ? 2'h3 : 2'(k); sm = (k != 1); en = 1;
        stop((k == 2) ? 4'h9 : 4'h1, k == 2);
    end
    if (q.size() != 0) fail_count++;
    conclude;
end
endmodule
